// File: src/adcab_top.sv
// register bank of a 10-bit converter behind a two-wire slave port
// assumes SCL and SDA samples synchronous to CLK_SYS_I, several clocks per bus bit,
// and a converter core that pulses done with its 10-bit result
`timescale 1ns/1ns
`include "adcab_params.svh"

module adcab_top
    import adcab_pkg::*;
#(
    parameter logic [6:0]  SLAVE_ADDR    = 7'h2a,       // arbitrary value
    parameter logic [23:0] CONV_UNIT_CYC = 24'h00000a   // clocks per conversion slot
) (
    input  wire logic       CLK_SYS_I,
    input  wire logic       RESETN_I,
    input  wire logic       SCL_I,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE_O,
    input  wire logic       CONV_DONE_I,
    input  wire logic [9:0] CONV_DATA_I,
    output logic            CONV_START_O
);
    adcab_state_t s_q;
    adcab_state_t s_d;
    adcab_conv_t  conv;
    logic         over_flag;
    logic         under_flag;
    logic         w1c_over;
    logic         w1c_under;
    logic         ptr_wr;
    logic         rd_conv;
    logic         scl_rise;
    logic         scl_fall;
    logic         bus_start;
    logic         bus_stop;
    logic [15:0]  rd_mux;
    logic [15:0]  wr_word;
    logic         wide;
    logic [10:0]  over_clr_lvl;
    logic [10:0]  under_clr_lvl;
    logic         set_over;
    logic         set_under;
    logic         clr_over;
    logic         clr_under;

    assign conv.done = CONV_DONE_I;
    assign conv.data = CONV_DATA_I;

    // =================================================================
    // bus edge and condition detect on the synchronous pin samples
    assign scl_rise  = SCL_I && !s_q.scl_p;
    assign scl_fall  = !SCL_I && s_q.scl_p;
    assign bus_start = SCL_I && s_q.scl_p && s_q.sda_p && !SDA_I;
    assign bus_stop  = SCL_I && s_q.scl_p && !s_q.sda_p && SDA_I;

    // =================================================================
    // read word per selected register; only the three low bits decode
    always_comb begin
        rd_mux = 16'h0000;
        wide   = 1'b1;
        case (s_q.ptr)
            `ADCAB_PTR_RESULT: begin
                rd_mux[`ADCAB_VAL_MSB:`ADCAB_VAL_LSB] = s_q.result;
                rd_mux[`ADCAB_RES_ALERT] = s_q.cfg[`ADCAB_CFG_FLAG_EN]
                                         && (over_flag || under_flag);
            end
            `ADCAB_PTR_STATUS: begin
                wide = 1'b0;
                rd_mux[`ADCAB_STAT_OVER]  = over_flag;
                rd_mux[`ADCAB_STAT_UNDER] = under_flag;
            end
            `ADCAB_PTR_CONFIG: begin
                wide        = 1'b0;
                rd_mux[7:0] = s_q.cfg;
            end
            `ADCAB_PTR_LOW:     rd_mux[`ADCAB_VAL_MSB:`ADCAB_VAL_LSB] = s_q.low_lim;
            `ADCAB_PTR_HIGH:    rd_mux[`ADCAB_VAL_MSB:`ADCAB_VAL_LSB] = s_q.high_lim;
            `ADCAB_PTR_HYST:    rd_mux[`ADCAB_VAL_MSB:`ADCAB_VAL_LSB] = s_q.hysteresis_value;
            `ADCAB_PTR_LOWEST:  rd_mux[`ADCAB_VAL_MSB:`ADCAB_VAL_LSB] = s_q.lowest;
            `ADCAB_PTR_HIGHEST: rd_mux[`ADCAB_VAL_MSB:`ADCAB_VAL_LSB] = s_q.highest;
            default:            rd_mux = 16'h0000;
        endcase
    end

    assign wr_word = {s_q.hold, s_q.shift};

    // =================================================================
    // alert compare; the 11-bit sum never wraps, the difference only counts while hysteresis is within the upper limit
    assign over_clr_lvl  = {1'b0, s_q.high_lim} - {1'b0, s_q.hysteresis_value};
    assign under_clr_lvl = {1'b0, s_q.low_lim} + {1'b0, s_q.hysteresis_value};
    assign set_over  = conv.done && (conv.data > s_q.high_lim);
    assign set_under = conv.done && (conv.data < s_q.low_lim);
    assign clr_over  = conv.done && (s_q.hysteresis_value <= s_q.high_lim)
                     && ({1'b0, conv.data} < over_clr_lvl);
    assign clr_under = conv.done && ({1'b0, conv.data} > under_clr_lvl);

    // =================================================================
    // next state: slave sequencer, register writes, conversion timing
    always_comb begin
        s_d            = s_q;
        s_d.scl_p      = SCL_I;
        s_d.sda_p      = SDA_I;
        s_d.conv_start = 1'b0;
        w1c_over       = 1'b0;
        w1c_under      = 1'b0;
        ptr_wr         = 1'b0;
        rd_conv        = 1'b0;
        if (bus_start) begin
            s_d.st     = ADCAB_ADDR;
            s_d.bitc   = 4'h0;
            s_d.sda_oe = 1'b0;
        end else if (bus_stop) begin
            s_d.st     = ADCAB_IDLE;                            // pointer kept
            s_d.sda_oe = 1'b0;
        end else begin
            case (s_q.st)
                ADCAB_ADDR, ADCAB_WR_BYTE: begin
                    if (scl_rise && s_q.bitc != 4'h8) begin
                        s_d.shift = {s_q.shift[6:0], SDA_I};
                        s_d.bitc  = s_q.bitc + 4'h1;
                    end else if (scl_fall && s_q.bitc == 4'h8) begin
                        s_d.sda_oe = 1'b1;
                        if (s_q.st == ADCAB_ADDR) begin
                            if (s_q.shift[7:1] == SLAVE_ADDR) begin
                                s_d.st    = ADCAB_ADDR_ACK;
                                s_d.rw    = s_q.shift[0];
                                s_d.first = 1'b1;
                            end else begin
                                s_d.st     = ADCAB_IDLE;
                                s_d.sda_oe = 1'b0;
                            end
                        end else begin
                            s_d.st = ADCAB_WR_ACK;
                            if (s_q.first) begin
                                s_d.ptr     = s_q.shift[2:0];
                                s_d.first   = 1'b0;
                                s_d.lo_next = 1'b0;
                                ptr_wr      = 1'b1;
                            end else if (wide && !s_q.lo_next) begin
                                s_d.hold    = s_q.shift;         // high byte first
                                s_d.lo_next = 1'b1;
                            end else begin
                                s_d.lo_next = 1'b0;
                                case (s_q.ptr)
                                    `ADCAB_PTR_STATUS: begin
                                        w1c_over  = s_q.shift[`ADCAB_STAT_OVER];
                                        w1c_under = s_q.shift[`ADCAB_STAT_UNDER];
                                    end
                                    `ADCAB_PTR_CONFIG:  s_d.cfg = s_q.shift & `ADCAB_CFG_WMASK;
                                    `ADCAB_PTR_LOW:     s_d.low_lim = wr_word[11:2];
                                    `ADCAB_PTR_HIGH:    s_d.high_lim = wr_word[11:2];
                                    `ADCAB_PTR_HYST:    s_d.hysteresis_value = wr_word[11:2];
                                    `ADCAB_PTR_LOWEST:  s_d.lowest = wr_word[11:2];
                                    `ADCAB_PTR_HIGHEST: s_d.highest = wr_word[11:2];
                                    default:            s_d.lo_next = 1'b0; // result is read-only
                                endcase
                            end
                        end
                    end
                end
                ADCAB_ADDR_ACK: begin
                    if (scl_fall) begin
                        s_d.bitc = 4'h0;
                        if (s_q.rw) begin
                            // this fall opens bit 7, so its level must go out now
                            s_d.st      = ADCAB_RD_BYTE;
                            s_d.bitc    = 4'h1;
                            s_d.rd_word = rd_mux;
                            s_d.sda_oe  = wide ? ~rd_mux[15] : ~rd_mux[7];
                            s_d.shift   = wide ? {rd_mux[14:8], 1'b0} : {rd_mux[6:0], 1'b0};
                            s_d.lo_next = wide;
                            rd_conv     = (s_q.ptr == `ADCAB_PTR_RESULT);
                            s_d.conv_start = rd_conv;
                        end else begin
                            s_d.st     = ADCAB_WR_BYTE;
                            s_d.sda_oe = 1'b0;
                        end
                    end
                end
                ADCAB_WR_ACK: begin
                    if (scl_fall) begin
                        s_d.st     = ADCAB_WR_BYTE;
                        s_d.sda_oe = 1'b0;
                        s_d.bitc   = 4'h0;
                    end
                end
                ADCAB_RD_BYTE: begin
                    // bit 7 leaves at the load; each later fall puts out the next bit
                    if (scl_fall) begin
                        if (s_q.bitc == 4'h8) begin
                            s_d.st     = ADCAB_RD_ACK;
                            s_d.sda_oe = 1'b0;
                        end else begin
                            s_d.sda_oe = ~s_q.shift[7];
                            s_d.shift  = {s_q.shift[6:0], 1'b0};
                            s_d.bitc   = s_q.bitc + 4'h1;
                        end
                    end
                end
                ADCAB_RD_ACK: begin
                    if (scl_rise && SDA_I) begin
                        s_d.st = ADCAB_IDLE;                    // master refused, wait stop
                    end else if (scl_fall) begin
                        s_d.st   = ADCAB_RD_BYTE;
                        s_d.bitc = 4'h1;
                        if (s_q.lo_next) begin
                            s_d.sda_oe  = ~s_q.rd_word[7];
                            s_d.shift   = {s_q.rd_word[6:0], 1'b0};
                            s_d.lo_next = 1'b0;
                        end else begin
                            // refetch so a repeated read shows fresh contents
                            s_d.rd_word = rd_mux;
                            s_d.sda_oe  = wide ? ~rd_mux[15] : ~rd_mux[7];
                            s_d.shift   = wide ? {rd_mux[14:8], 1'b0} : {rd_mux[6:0], 1'b0};
                            s_d.lo_next = wide;
                        end
                    end
                end
                default: s_d.sda_oe = 1'b0;
            endcase
        end
        // automatic conversion: interval is unit times 2^(code+4)
        if (s_q.cfg[`ADCAB_CFG_CYC_MSB:`ADCAB_CFG_CYC_LSB] == 3'h0) begin
            s_d.timer = 24'h000000;
        end else if (s_q.timer == 24'h000000) begin
            s_d.conv_start = 1'b1;
            s_d.timer = (CONV_UNIT_CYC << ({1'b0, s_q.cfg[`ADCAB_CFG_CYC_MSB:`ADCAB_CFG_CYC_LSB]}
                        + `ADCAB_AUTO_SHIFT)) - 24'h000001;
        end else begin
            s_d.timer = s_q.timer - 24'h000001;
        end
        // a finished conversion updates result and extremes after any write
        if (conv.done) begin
            s_d.result = conv.data;
            if (conv.data < s_q.lowest) begin
                s_d.lowest = conv.data;
            end
            if (conv.data > s_q.highest) begin
                s_d.highest = conv.data;
            end
        end
    end

    // =================================================================
    // state register
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s_q                  <= '0;
            s_q.st               <= ADCAB_IDLE;
            s_q.scl_p            <= 1'b1;
            s_q.sda_p            <= 1'b1;
            s_q.cfg              <= `ADCAB_RST_CONFIG;
            s_q.low_lim          <= `ADCAB_RST_LOW;
            s_q.high_lim         <= `ADCAB_RST_HIGH;
            s_q.hysteresis_value <= `ADCAB_RST_HYST;
            s_q.lowest           <= `ADCAB_RST_LOWEST;
            s_q.highest          <= `ADCAB_RST_HIGHEST;
        end else begin
            s_q <= s_d;
        end
    end

    // =================================================================
    // alert flags; hold comes straight from the configuration
    adcab_flag_cell u_over (
        .clk_i      (CLK_SYS_I),
        .resetn_i   (RESETN_I),
        .set_i      (set_over),
        .self_clr_i (clr_over),
        .hold_i     (s_q.cfg[`ADCAB_CFG_HOLD]),
        .w1c_i      (w1c_over),
        .flag_o     (over_flag)
    );
    adcab_flag_cell u_under (
        .clk_i      (CLK_SYS_I),
        .resetn_i   (RESETN_I),
        .set_i      (set_under),
        .self_clr_i (clr_under),
        .hold_i     (s_q.cfg[`ADCAB_CFG_HOLD]),
        .w1c_i      (w1c_under),
        .flag_o     (under_flag)
    );

    // =================================================================
    // pins: open drain, data always low, enable from a flip-flop
    assign SDA_O        = 1'b0;
    assign SDA_OE_O     = s_q.sda_oe;
    assign CONV_START_O = s_q.conv_start;

    // =================================================================
    // checks
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);

    AST_PTR_ONLY_BY_WRITE: assert property ($changed(s_q.ptr) |-> $past(ptr_wr))
        else $error("pointer moved outside a pointer byte");
    AST_RESULT_RO: assert property ($changed(s_q.result) |-> $past(CONV_DONE_I))
        else $error("result changed without a conversion");
    AST_RESULT_LOAD: assert property (CONV_DONE_I |=> s_q.result == $past(CONV_DATA_I))
        else $error("result not loaded from conversion");
    AST_RESULT_FMT: assert property (s_q.ptr == `ADCAB_PTR_RESULT |->
        rd_mux[14:12] == 3'h0 && rd_mux[1:0] == 2'h0
        && rd_mux[15] == (s_q.cfg[3] && (over_flag || under_flag)))
        else $error("result word format wrong");
    AST_OVER_SET: assert property (set_over |=> over_flag)
        else $error("over-range flag not set");
    AST_UNDER_SET: assert property (set_under |=> under_flag)
        else $error("under-range flag not set");
    AST_OVER_SELF_CLR: assert property (clr_over && !set_over && !s_q.cfg[4] |=> !over_flag)
        else $error("over-range flag did not self-clear");
    AST_UNDER_SELF_CLR: assert property (clr_under && !set_under && !s_q.cfg[4] |=> !under_flag)
        else $error("under-range flag did not self-clear");
    AST_ZERO_WRITE_KEEPS: assert property (over_flag && !w1c_over && !(clr_over && !s_q.cfg[4]) |=> over_flag)
        else $error("over-range flag lost without a clear");
    AST_STATUS_RSV: assert property (s_q.ptr == `ADCAB_PTR_STATUS |-> rd_mux[15:2] == 14'h0000)
        else $error("status reserved bits not zero");
    AST_READ_CONVERTS: assert property (rd_conv |=> CONV_START_O ##1 !CONV_START_O)
        else $error("result read did not start one conversion");

    COV_PTR_WRITE: cover property (ptr_wr);
    COV_RESULT_READ: cover property (rd_conv);
    COV_OVER_ALERT: cover property (set_over ##1 over_flag);
    COV_AUTO_START: cover property (s_q.cfg[7:5] != 3'h0 && CONV_START_O);

endmodule

// File: src/adcab_params.svh
// constants of the converter register bank: pointer codes, field positions, reset values, timing
// assumes inclusion by the package and the design modules of the same bank
//
// Contract
// - every register loads its default at reset and keeps it until changed
// - eight data registers plus a pointer; the result register alone is read-only
// - first data byte of each write transaction becomes the new pointer
// - the pointer selects the register for following written or read bytes
// - only the lowest three pointer bits are decoded; master writes upper zeros
// - pointer is zero after reset, selecting the conversion result
// - select 0..7 maps result, status, config, low, high, hysteresis, lowest, highest
// - result word holds the 10-bit value in bits 11:2; 14:12 and 1:0 read zero
// - result bit 15 is high only with flag enable set and an alert flag set
// - over-range flag bit 1 sets when a conversion exceeds the upper limit
// - under-range flag bit 0 sets when a conversion falls below the lower limit
// - writing one to a flag clears it; writing zero leaves it
// - over-range self-clears below upper limit minus hysteresis when hold is off
// - under-range self-clears above lower limit plus hysteresis when hold is off
// - with hold on, flags clear only by a written one
// - status bits 7:2 always read zero; master writes zeros there
// - a conversion starts on each result read and repeatedly in automatic mode; only the first word of a read transaction starts one here
// - configuration bit 3 gates result bit 15
// - configuration bit 4 selects alert hold against hysteresis self-clear
`ifndef ADCAB_PARAMS_SVH
`define ADCAB_PARAMS_SVH

// =====================================================================
// pointer codes
`define ADCAB_PTR_RESULT   3'h0
`define ADCAB_PTR_STATUS   3'h1
`define ADCAB_PTR_CONFIG   3'h2
`define ADCAB_PTR_LOW      3'h3
`define ADCAB_PTR_HIGH     3'h4
`define ADCAB_PTR_HYST     3'h5
`define ADCAB_PTR_LOWEST   3'h6
`define ADCAB_PTR_HIGHEST  3'h7

// =====================================================================
// field positions
`define ADCAB_CFG_CYC_MSB  7
`define ADCAB_CFG_CYC_LSB  5
`define ADCAB_CFG_HOLD     4
`define ADCAB_CFG_FLAG_EN  3
`define ADCAB_CFG_WMASK    8'hfd
`define ADCAB_STAT_OVER    1
`define ADCAB_STAT_UNDER   0
`define ADCAB_RES_ALERT    15
`define ADCAB_VAL_MSB      11
`define ADCAB_VAL_LSB      2

// =====================================================================
// reset values of the 10-bit fields and the configuration
`define ADCAB_RST_CONFIG   8'h00
`define ADCAB_RST_LOW      10'h000
`define ADCAB_RST_HIGH     10'h3ff
`define ADCAB_RST_HYST     10'h000
`define ADCAB_RST_LOWEST   10'h3ff
`define ADCAB_RST_HIGHEST  10'h000

// =====================================================================
// automatic mode: interval is the unit shifted by cycle code plus this
`define ADCAB_AUTO_SHIFT   4'h4

`endif

// File: src/adcab_pkg.sv
// types of the converter register bank
// assumes the params header for field positions
package adcab_pkg;

    // =================================================================
    // two-wire slave sequencer states
    typedef enum logic [2:0] {
        ADCAB_IDLE,
        ADCAB_ADDR,
        ADCAB_ADDR_ACK,
        ADCAB_WR_BYTE,
        ADCAB_WR_ACK,
        ADCAB_RD_BYTE,
        ADCAB_RD_ACK
    } adcab_st_t;

    // =================================================================
    // whole state of the bank top
    typedef struct packed {
        adcab_st_t   st;
        logic        scl_p;
        logic        sda_p;
        logic [3:0]  bitc;
        logic [7:0]  shift;
        logic        rw;
        logic        first;
        logic        lo_next;
        logic [7:0]  hold;
        logic [15:0] rd_word;
        logic        sda_oe;
        logic [2:0]  ptr;
        logic [9:0]  result;
        logic [7:0]  cfg;
        logic [9:0]  low_lim;
        logic [9:0]  high_lim;
        logic [9:0]  hysteresis_value;
        logic [9:0]  lowest;
        logic [9:0]  highest;
        logic [23:0] timer;
        logic        conv_start;
    } adcab_state_t;

    // =================================================================
    // state of one alert flag cell
    typedef struct packed {
        logic flag;
    } adcab_flag_state_t;

    // =================================================================
    // conversion result from the converter core
    typedef struct packed {
        logic       done;
        logic [9:0] data;
    } adcab_conv_t;

endpackage

// File: src/adcab_flag_cell.sv
// one sticky alert flag with written-one clear and hysteresis self-clear
// assumes set and clear terms are single-cycle and synchronous to the clock
`timescale 1ns/1ns
`include "adcab_params.svh"

module adcab_flag_cell
    import adcab_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic set_i,
    input  wire logic self_clr_i,
    input  wire logic hold_i,
    input  wire logic w1c_i,
    output logic      flag_o
);
    adcab_flag_state_t s_q;
    adcab_flag_state_t s_d;

    // =================================================================
    // next value: a set wins over any clear in the same cycle
    always_comb begin
        s_d = s_q;
        if (set_i) begin
            s_d.flag = 1'b1;
        end else if (w1c_i) begin
            s_d.flag = 1'b0;
        end else if (self_clr_i && !hold_i) begin
            s_d.flag = 1'b0;
        end
    end

    // =================================================================
    // register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag_o = s_q.flag;

    // =================================================================
    // checks
    AST_HOLD_KEEPS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_q.flag && hold_i && !w1c_i |=> s_q.flag)
        else $error("held flag cleared without a written one");
    AST_W1C_CLEARS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        w1c_i && !set_i |=> !s_q.flag)
        else $error("written one did not clear the flag");

endmodule

// File: bench/adcab_i2c_model.sv
// two-wire bus controller model: drives the clock and pulls data low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ns
module adcab_i2c_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    // ==========================================
    // bus phases; each step stands four clocks, so the clock stays low eight and high four
    task automatic half();
        repeat (4) @(posedge clk_i);
    endtask
    task automatic bitx(input logic b, output logic r);
        half();
        sda_oe_o <= ~b; // data moves only while the clock is low
        half();
        scl_o <= 1'b1;
        half();
        r = sda_i;
        scl_o <= 1'b0;
    endtask
    task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(a, r);
    endtask
    task automatic start();
        half();
        sda_oe_o <= 1'b0;
        scl_o <= 1'b1;
        half();
        sda_oe_o <= 1'b1;
        half();
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        half();
        sda_oe_o <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        sda_oe_o <= 1'b0;
    endtask
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
endmodule

// File: bench/tb_adc_alert_register_bank.sv
// self-checking bench of the converter register bank
// assumes the bus model drives the port; the bench plays the converter core
`timescale 1ns/1ns
module tb_adc_alert_register_bank;
    logic clk = 1'b0, rstn = 1'b0, done = 1'b0, scl, moe, soe;
    logic [9:0] data = 10'h000, d;
    logic [15:0] w;
    logic [1:0] fl;
    logic [15:0] nst = 16'h0000, t0;
    logic start;
    int num_errors = 0, comparisons = 0, cyc = 0;
    wire sda = ~(moe | soe); // pull-up unless someone pulls low
    always #50 clk = ~clk;
    adcab_top #(.CONV_UNIT_CYC(24'h000002)) dut_u (.CLK_SYS_I(clk), .RESETN_I(rstn), .SCL_I(scl),
        .SDA_I(sda), .SDA_O(), .SDA_OE_O(soe), .CONV_DONE_I(done), .CONV_DATA_I(data), .CONV_START_O(start));
    adcab_i2c_model m_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(moe));
    // ==========================================
    // shared transfers and comparison
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [2:0] p, input logic [15:0] v, input bit wide);
        logic [7:0] q;
        m_u.start();
        m_u.xbyte(8'h54, 1'b1, q);
        m_u.xbyte({5'h00, p}, 1'b1, q);
        if (wide) m_u.xbyte(v[15:8], 1'b1, q);
        m_u.xbyte(v[7:0], 1'b1, q);
        m_u.stop();
    endtask
    task automatic rd(input logic [2:0] p, output logic [15:0] v);
        logic [7:0] q;
        m_u.start();
        m_u.xbyte(8'h54, 1'b1, q);
        m_u.xbyte({5'h00, p}, 1'b1, q);
        m_u.start();
        m_u.xbyte(8'h55, 1'b1, q);
        m_u.xbyte(8'hff, 1'b0, v[15:8]);
        m_u.xbyte(8'hff, 1'b1, v[7:0]);
        m_u.stop();
    endtask
    task automatic conv(input logic [9:0] x);
        @(posedge clk);
        done <= 1'b1;
        data <= x;
        @(posedge clk);
        done <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // conversion starts asked of the core
    always @(posedge clk) begin
        if (start) nst <= nst + 16'h0001;
    end
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            wrap_up();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        logic [9:0] tv [6] = '{10'h3ff, 10'h1f8, 10'h1e0, 10'h000, 10'h108, 10'h120};
        logic [1:0] ts [6] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0};
        void'($urandom(24945));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        rd(3'h0, w);
        chk("result", 16'h0000, w);
        // limits 100/200, hysteresis 10, hold off; walk through set and self-clear
        wr(3'h2, 16'h0008, 1'b0);
        wr(3'h5, 16'h0040, 1'b1);
        wr(3'h4, 16'h0800, 1'b1);
        wr(3'h3, 16'h0400, 1'b1);
        for (int i = 0; i < 6; i++) begin
            conv(tv[i]);
            rd(3'h1, w);
            chk("status", {8'h00, 6'h00, ts[i]}, {8'h00, w[15:8]});
            rd(3'h0, w);
            chk("result", {|ts[i], 3'h0, tv[i], 2'h0}, w);
        end
        // read-only result ignores writes; the other words read back as written or seen
        wr(3'h0, 16'hffff, 1'b1);
        rd(3'h0, w);
        chk("result ro", 16'h0480, w);
        rd(3'h3, w);
        chk("low", 16'h0400, w);
        rd(3'h4, w);
        chk("high", 16'h0800, w);
        rd(3'h5, w);
        chk("hysteresis", 16'h0040, w);
        rd(3'h6, w);
        chk("lowest", 16'h0000, w);
        rd(3'h7, w);
        chk("highest", 16'h0ffc, w);
        // hold on: flags stay until cleared by a written one
        wr(3'h2, 16'h0018, 1'b0);
        rd(3'h2, w);
        chk("config", 16'h0018, {8'h00, w[15:8]});
        fl = 2'h0;
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 10'h200 : (i == 1) ? 10'h3ff : 10'($urandom_range(1023));
            conv(d);
            fl |= {d > 10'h200, d < 10'h100};
            rd(3'h0, w);
            chk("result", {|fl, 3'h0, d, 2'h0}, w);
        end
        wr(3'h1, 16'h0000, 1'b0);
        rd(3'h1, w);
        chk("status", {8'h00, 6'h00, fl}, {8'h00, w[15:8]});
        wr(3'h1, 16'h0003, 1'b0);
        rd(3'h1, w);
        chk("status", 16'h0000, {8'h00, w[15:8]});
        // each result read started one conversion; auto code 1 repeats every unit times 2^5
        chk("starts", 16'h0010, nst);
        wr(3'h2, 16'h0020, 1'b0);
        @(posedge clk iff start);
        t0 = cyc[15:0];
        @(posedge clk iff start);
        chk("interval", 16'h0040, cyc[15:0] - t0);
        wr(3'h2, 16'h0000, 1'b0);
        wrap_up();
    end
endmodule
